/* File: design/pmcp_guard.sv */
// Program memory code protection guard with table-read and programmer paths
// Summary of operation
// - An active code-protect bit blocks programmer reads and writes of user program memory only.
// - Table reads reach program memory, the device identification words and the config bytes.
// - A set external-table-read protect bit stops external-code table reads of guarded memory.
// - The external-table-read protect logic exists only when the external bus is present.
// - In extended microcontroller mode the whole on-chip program memory is guarded.
// - In boot block mode only addresses 000h to 7FFh are guarded.
// - In microcontroller and microprocessor modes the external read protect bit does nothing.
// - Configuration bytes are written only through the serial programming port.
// - Program memory is one block from 000000h; unimplemented space to 1FFFFFh reads zero.
// - Eight ID bytes at 200000h to 200007h are readable by table reads.
// - In program/verify mode the ID bytes are readable and writable.
// - ID bytes read back even while code protection is active.
// - A debug config bit at zero enables the debugger and reserves two stack levels for it.
// - Serial programming uses one clock line and one data line.
`timescale 1ns/1ps
`default_nettype none
module pmcp_guard #(
  parameter int PROG_BYTES = pmcp_pkg::PROG_BYTES_16K,
  parameter bit HAS_EXT_BUS = 1'b1,
  // Arbitrary neutral identification value
  parameter logic [15:0] DEVICE_ID = 16'h5a00
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire pmcp_pkg::pmcp_mode_t i_mode,
  input wire logic i_trd_req,
  input wire logic [21:0] i_trd_addr,
  input wire logic i_trd_from_ext,
  output logic o_trd_valid,
  output logic [7:0] o_trd_data,
  output logic o_trd_blocked,
  input wire logic i_programming_voltage_on,
  input wire logic i_debug_clock_pin,
  input wire logic i_debug_data_pin,
  output logic o_debug_data_pin,
  output logic o_debug_data_pin_oe_b,
  output logic o_prg_denied,
  output logic o_code_protected,
  output logic o_debug_en,
  output logic [1:0] o_debug_stack_levels
);
  localparam int PW = $clog2(PROG_BYTES);
  localparam int CP_IDX = int'(pmcp_pkg::CODE_PROTECT_CONFIG - pmcp_pkg::CFG_BASE);
  localparam int ER_IDX = int'(pmcp_pkg::EXTERNAL_READ_PROTECT_CONFIG - pmcp_pkg::CFG_BASE);
  localparam int DB_IDX = int'(pmcp_pkg::DEBUG_CONFIG - pmcp_pkg::CFG_BASE);
  // Index widths of the small byte arrays
  localparam int ID_W = $clog2(pmcp_pkg::ID_COUNT);
  localparam int CFG_W = $clog2(pmcp_pkg::CFG_COUNT);

  pmcp_prg_if prg ();

  // Storage
  logic [7:0] prog_mem [PROG_BYTES];
  logic [7:0] id_mem [pmcp_pkg::ID_COUNT];
  logic [7:0] cfg_q [pmcp_pkg::CFG_COUNT];
  logic [7:0] cfg_d [pmcp_pkg::CFG_COUNT];
  // Registered answers and decode
  logic trd_valid_q, trd_valid_d;
  logic [7:0] trd_data_q, trd_data_d;
  logic trd_blocked_q, trd_blocked_d;
  logic [7:0] prg_rdata_q, prg_rdata_d;
  logic prg_rvalid_q, prg_rvalid_d;
  logic prg_denied_q, prg_denied_d;
  logic debug_en_q, debug_en_d;
  logic [1:0] dbg_stack_q, dbg_stack_d;
  logic cp_on, external_table_read_protect_bit_on, ext_guard, prg_prot, prg_wr_ok;
  logic prg_hit_prog, prg_hit_id, prg_hit_cfg;
  logic prog_we, id_we;

  // Address decode
  function automatic logic in_prog(input logic [21:0] a);
    return a < 22'(PROG_BYTES);
  endfunction

  function automatic logic in_id(input logic [21:0] a);
    return (a >= pmcp_pkg::ID_BASE) && (a <= pmcp_pkg::ID_LAST);
  endfunction

  function automatic logic in_cfg(input logic [21:0] a);
    return (a >= pmcp_pkg::CFG_BASE) && (a <= pmcp_pkg::CFG_LAST);
  endfunction

  function automatic logic [7:0] read_byte(input logic [21:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (in_prog(a))
      v = prog_mem[a[PW-1:0]];
    else if (in_id(a))
      v = id_mem[a[ID_W-1:0]];
    else if (in_cfg(a))
      v = cfg_q[a[CFG_W-1:0]];
    else if (a == pmcp_pkg::DEVID_LO)
      v = DEVICE_ID[7:0];
    else if (a == pmcp_pkg::DEVID_HI)
      v = DEVICE_ID[15:8];
    return v;
  endfunction

  // Serial programming port
  pmcp_serial_port u_port (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_enable(i_programming_voltage_on),
    .i_clk_pin(i_debug_clock_pin),
    .i_data_pin(i_debug_data_pin),
    .o_data_pin(o_debug_data_pin),
    .o_data_oe_b(o_debug_data_pin_oe_b),
    .bus(prg.port)
  );

  // Table read path
  always_comb
  begin
    cp_on = cfg_q[CP_IDX][pmcp_pkg::CODE_PROTECT_BIT];
    external_table_read_protect_bit_on = HAS_EXT_BUS && cfg_q[ER_IDX][pmcp_pkg::EXT_TABLE_READ_PROTECT_BIT];
    ext_guard = 1'b0;
    unique case (i_mode)
      pmcp_pkg::PMCP_MODE_EXTENDED:
        ext_guard = in_prog(i_trd_addr);
      pmcp_pkg::PMCP_MODE_BOOT_BLOCK:
        ext_guard = i_trd_addr <= pmcp_pkg::BOOT_BLOCK_LAST;
      pmcp_pkg::PMCP_MODE_MICROCONTROLLER,
      pmcp_pkg::PMCP_MODE_MICROPROCESSOR:
        ext_guard = 1'b0;
    endcase
    ext_guard = ext_guard && external_table_read_protect_bit_on && i_trd_from_ext;
    trd_valid_d = i_trd_req;
    trd_blocked_d = i_trd_req && ext_guard;
    trd_data_d = trd_data_q;
    if (i_trd_req)
      trd_data_d = ext_guard ? 8'h00 : read_byte(i_trd_addr);
  end

  // Programmer path and config updates
  always_comb
  begin
    prg_hit_prog = in_prog(prg.addr);
    prg_hit_id = in_id(prg.addr);
    prg_hit_cfg = in_cfg(prg.addr);
    prg_prot = prg_hit_prog && cp_on;
    prg_wr_ok = prg.req && prg.we && i_programming_voltage_on && !prg_prot;
    prog_we = prg_wr_ok && prg_hit_prog;
    id_we = prg_wr_ok && prg_hit_id;
    for (int i = 0; i < pmcp_pkg::CFG_COUNT; i++)
      cfg_d[i] = cfg_q[i];
    if (prg_wr_ok && prg_hit_cfg)
      cfg_d[prg.addr[CFG_W-1:0]] = prg.wdata;
    prg_rvalid_d = prg.req && !prg.we;
    prg_denied_d = prg.req && prg_prot;
    prg_rdata_d = prg_rdata_q;
    if (prg.req && !prg.we)
      prg_rdata_d = prg_prot ? 8'h00 : read_byte(prg.addr);
    debug_en_d = ~cfg_q[DB_IDX][pmcp_pkg::DEBUG_BIT];
    dbg_stack_d = debug_en_d ? pmcp_pkg::DBG_STACK_LEVELS : 2'h0;
  end

  // Memories written by the programmer
  always_ff @(posedge i_ref_clk)
  begin
    if (prog_we)
      prog_mem[prg.addr[PW-1:0]] <= prg.wdata;
    if (id_we)
      id_mem[prg.addr[ID_W-1:0]] <= prg.wdata;
  end

  // Table read registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      trd_valid_q <= 1'b0;
      trd_data_q <= 8'h00;
      trd_blocked_q <= 1'b0;
    end
    else
    begin
      trd_valid_q <= trd_valid_d;
      trd_data_q <= trd_data_d;
      trd_blocked_q <= trd_blocked_d;
    end
  end

  // Programmer, config and debugger registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < pmcp_pkg::CFG_COUNT; i++)
        cfg_q[i] <= pmcp_pkg::CFG_RESET;
      prg_rdata_q <= 8'h00;
      prg_rvalid_q <= 1'b0;
      prg_denied_q <= 1'b0;
      debug_en_q <= 1'b0;
      dbg_stack_q <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < pmcp_pkg::CFG_COUNT; i++)
        cfg_q[i] <= cfg_d[i];
      prg_rdata_q <= prg_rdata_d;
      prg_rvalid_q <= prg_rvalid_d;
      prg_denied_q <= prg_denied_d;
      debug_en_q <= debug_en_d;
      dbg_stack_q <= dbg_stack_d;
    end
  end

  // Outputs straight from registers
  assign prg.rdata = prg_rdata_q;
  assign prg.rvalid = prg_rvalid_q;
  assign o_trd_valid = trd_valid_q;
  assign o_trd_data = trd_data_q;
  assign o_trd_blocked = trd_blocked_q;
  assign o_prg_denied = prg_denied_q;
  assign o_code_protected = cfg_q[CP_IDX][pmcp_pkg::CODE_PROTECT_BIT];
  assign o_debug_en = debug_en_q;
  assign o_debug_stack_levels = dbg_stack_q;
endmodule
`default_nettype wire

/* File: design/pmcp_pkg.sv */
// Constants and types shared by the program memory code protection guard
package pmcp_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;
  localparam int FRAME_W = 1 + ADDR_W + DATA_W;
  localparam int PROG_BYTES_8K = 8192;
  localparam int PROG_BYTES_16K = 16384;
  localparam logic [21:0] BOOT_BLOCK_LAST = 22'h0007ff;
  localparam logic [21:0] UNIMPL_LAST = 22'h1fffff;
  localparam logic [21:0] ID_BASE = 22'h200000;
  localparam logic [21:0] ID_LAST = 22'h200007;
  localparam logic [21:0] CFG_BASE = 22'h300000;
  localparam logic [21:0] CFG_LAST = 22'h30000d;
  localparam logic [21:0] DEBUG_CONFIG = 22'h300006;
  localparam logic [21:0] CODE_PROTECT_CONFIG = 22'h300008;
  localparam logic [21:0] EXTERNAL_READ_PROTECT_CONFIG = 22'h30000c;
  localparam logic [21:0] DEVID_LO = 22'h3ffffe;
  localparam logic [21:0] DEVID_HI = 22'h3fffff;
  localparam int CFG_COUNT = 14;
  localparam int ID_COUNT = 8;
  localparam int CODE_PROTECT_BIT = 0;
  localparam int EXT_TABLE_READ_PROTECT_BIT = 0;
  localparam int DEBUG_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam logic [1:0] DBG_STACK_LEVELS = 2'h2;
  localparam logic [7:0] DBG_DATA_BYTES = 8'h10;
  localparam logic [4:0] SEND_LAST = 5'h07;
  typedef enum logic [1:0] {
    PMCP_MODE_MICROPROCESSOR,
    PMCP_MODE_MICROCONTROLLER,
    PMCP_MODE_EXTENDED,
    PMCP_MODE_BOOT_BLOCK
  } pmcp_mode_t;
  typedef enum logic [1:0] {
    PMCP_SER_RECV,
    PMCP_SER_WAIT,
    PMCP_SER_SEND
  } pmcp_ser_state_t;
endpackage

/* File: design/pmcp_prg_if.sv */
// Programmer request and answer between serial port and guard
`timescale 1ns/1ps
`default_nettype none
interface pmcp_prg_if;
  logic req;
  logic we;
  logic [21:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  modport port (output req, output we, output addr, output wdata, input rdata, input rvalid);
  modport guard (input req, input we, input addr, input wdata, output rdata, output rvalid);
endinterface
`default_nettype wire

/* File: design/pmcp_serial_port.sv */
// Two-wire serial programming port frame receiver and read-back shifter
`timescale 1ns/1ps
`default_nettype none
module pmcp_serial_port (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic i_clk_pin,
  input wire logic i_data_pin,
  output logic o_data_pin,
  output logic o_data_oe_b,
  pmcp_prg_if.port bus
);
  pmcp_pkg::pmcp_ser_state_t state_q, state_d;
  logic [pmcp_pkg::FRAME_W-1:0] shift_q, shift_d;
  logic [4:0] cnt_q, cnt_d;
  logic clk_prev_q, clk_prev_d;
  logic [7:0] out_q, out_d;
  logic req_q, req_d;
  logic oe_b_q, oe_b_d;
  logic rise;

  always_comb
  begin
    rise = i_clk_pin & ~clk_prev_q;
    state_d = state_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    out_d = out_q;
    oe_b_d = oe_b_q;
    req_d = 1'b0;
    clk_prev_d = i_clk_pin;
    if (!i_enable)
    begin
      state_d = pmcp_pkg::PMCP_SER_RECV;
      cnt_d = 5'h00;
      oe_b_d = 1'b1;
    end
    else
    begin
      unique case (state_q)
        pmcp_pkg::PMCP_SER_RECV:
        begin
          if (rise)
          begin
            shift_d = {shift_q[pmcp_pkg::FRAME_W-2:0], i_data_pin};
            if (cnt_q == 5'(pmcp_pkg::FRAME_W - 1))
            begin
              cnt_d = 5'h00;
              req_d = 1'b1;
              state_d = shift_d[pmcp_pkg::FRAME_W-1] ? pmcp_pkg::PMCP_SER_RECV :
                pmcp_pkg::PMCP_SER_WAIT;
            end
            else
            begin
              cnt_d = cnt_q + 5'h01;
            end
          end
        end
        pmcp_pkg::PMCP_SER_WAIT:
        begin
          if (bus.rvalid)
          begin
            out_d = bus.rdata;
            oe_b_d = 1'b0;
            cnt_d = 5'h00;
            state_d = pmcp_pkg::PMCP_SER_SEND;
          end
        end
        pmcp_pkg::PMCP_SER_SEND:
        begin
          if (rise)
          begin
            if (cnt_q == pmcp_pkg::SEND_LAST)
            begin
              oe_b_d = 1'b1;
              cnt_d = 5'h00;
              state_d = pmcp_pkg::PMCP_SER_RECV;
            end
            else
            begin
              out_d = {out_q[6:0], 1'b0};
              cnt_d = cnt_q + 5'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= pmcp_pkg::PMCP_SER_RECV;
      shift_q <= '0;
      cnt_q <= 5'h00;
      clk_prev_q <= 1'b0;
      out_q <= 8'h00;
      req_q <= 1'b0;
      oe_b_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      clk_prev_q <= clk_prev_d;
      out_q <= out_d;
      req_q <= req_d;
      oe_b_q <= oe_b_d;
    end
  end

  assign bus.req = req_q;
  assign bus.we = shift_q[pmcp_pkg::FRAME_W-1];
  assign bus.addr = shift_q[pmcp_pkg::FRAME_W-2:pmcp_pkg::DATA_W];
  assign bus.wdata = shift_q[pmcp_pkg::DATA_W-1:0];
  assign o_data_pin = out_q[7];
  assign o_data_oe_b = oe_b_q;
endmodule
`default_nettype wire

/* File: tb/pmcp_guard_sva.sv */
// Port assertions for the code protection guard
`timescale 1ns/1ps
`default_nettype none
module pmcp_guard_sva #(
  parameter int PROG_BYTES = 16384
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire pmcp_pkg::pmcp_mode_t i_mode,
  input wire logic i_trd_req,
  input wire logic [21:0] i_trd_addr,
  input wire logic i_trd_from_ext,
  input wire logic o_trd_valid,
  input wire logic [7:0] o_trd_data,
  input wire logic o_trd_blocked,
  input wire logic o_prg_denied,
  input wire logic o_code_protected,
  input wire logic o_debug_en,
  input wire logic [1:0] o_debug_stack_levels
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_ans;
    o_trd_valid;
  endsequence
  sequence s_open;
    o_trd_valid && !o_trd_blocked;
  endsequence
  a_trd_answer: assert property (i_trd_req |=> s_ans)
    else $error("read not answered");
  a_trd_quiet: assert property (!i_trd_req |=> !o_trd_valid)
    else $error("stray read answer");
  a_blk_zero: assert property (o_trd_blocked |-> s_ans and o_trd_data == 8'h00)
    else $error("blocked read not zero");
  a_mode_free: assert property (i_trd_req && (i_mode == pmcp_pkg::PMCP_MODE_MICROPROCESSOR
    || i_mode == pmcp_pkg::PMCP_MODE_MICROCONTROLLER) |=> s_open)
    else $error("guard active in free mode");
  a_boot_edge: assert property (i_trd_req && i_mode == pmcp_pkg::PMCP_MODE_BOOT_BLOCK
    && i_trd_addr > pmcp_pkg::BOOT_BLOCK_LAST |=> s_open)
    else $error("boot guard too wide");
  a_int_code: assert property (i_trd_req && !i_trd_from_ext |=> s_open)
    else $error("internal read blocked");
  a_id_open: assert property (i_trd_req && i_trd_addr >= pmcp_pkg::ID_BASE
    && i_trd_addr <= pmcp_pkg::ID_LAST |=> s_open)
    else $error("id read blocked");
  a_unimpl_zero: assert property (i_trd_req && i_trd_addr >= PROG_BYTES
    && i_trd_addr <= pmcp_pkg::UNIMPL_LAST |=> o_trd_data == 8'h00)
    else $error("unimplemented not zero");
  a_dbg_stack: assert property (o_debug_stack_levels
    == (o_debug_en ? pmcp_pkg::DBG_STACK_LEVELS : 2'h0))
    else $error("stack reserve wrong");
  a_deny_cp: assert property (o_prg_denied |-> o_code_protected)
    else $error("denied without protect");
endmodule
`default_nettype wire

/* File: tb/pmcp_prog_model.sv */
// Serial programmer model on the two-wire programming port
`timescale 1ns/1ps
`default_nettype none
module pmcp_prog_model (
  input wire logic i_ref_clk,
  input wire logic i_data_pin,
  output logic o_clk_pin,
  output logic o_data_pin
);
  logic [30:0] sr;
  initial
  begin
    o_clk_pin = 1'b0;
    o_data_pin = 1'b0;
  end
  task automatic half(input logic c);
    o_clk_pin <= c;
    repeat (2) @(posedge i_ref_clk);
  endtask
  // Config bytes reach the device only through this port
  task automatic xfer(input logic we, input logic [21:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int i;
    sr = {we, a, d};
    for (i = 30; i >= 0; i--)
    begin
      o_data_pin <= sr[i];
      half(1'b0);
      half(1'b1);
    end
    half(1'b0);
    o_data_pin <= ~sr[0];
    repeat (6) @(posedge i_ref_clk);
    if (!we)
    begin
      for (i = 7; i >= 0; i--)
      begin
        q[i] = i_data_pin;
        half(1'b1);
        half(1'b0);
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_pmcp_guard.sv */
// Testbench for the code protection guard
`timescale 1ns/1ps
`default_nettype none
module tb_pmcp_guard;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pmcp_pkg::pmcp_mode_t mode = pmcp_pkg::PMCP_MODE_MICROCONTROLLER;
  logic req = 1'b0;
  logic [21:0] addr = 22'h0;
  logic ext = 1'b0;
  logic pv = 1'b0;
  logic pclk, pdat, ddat, doe_b, valid, blk, den, cp, dbg, dpin, blk_nb;
  logic [7:0] data, q;
  logic [1:0] stk;
  logic seen = 1'b0;
  int cyc = 0;
  int err_count = 0;
  int num_checks = 0;
  assign dpin = doe_b ? pdat : ddat;
  always #12.5 clk = ~clk;
  pmcp_guard uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_mode(mode), .i_trd_req(req),
    .i_trd_addr(addr), .i_trd_from_ext(ext), .o_trd_valid(valid), .o_trd_data(data),
    .o_trd_blocked(blk), .i_programming_voltage_on(pv), .i_debug_clock_pin(pclk),
    .i_debug_data_pin(dpin), .o_debug_data_pin(ddat), .o_debug_data_pin_oe_b(doe_b),
    .o_prg_denied(den), .o_code_protected(cp), .o_debug_en(dbg),
    .o_debug_stack_levels(stk));
  // Variant without the external bus shares every input with the first instance
  pmcp_guard #(.HAS_EXT_BUS(1'b0)) uut_nb (.i_ref_clk(clk), .i_rst_b(rst_b), .i_mode(mode),
    .i_trd_req(req), .i_trd_addr(addr), .i_trd_from_ext(ext), .o_trd_valid(),
    .o_trd_data(), .o_trd_blocked(blk_nb), .i_programming_voltage_on(pv),
    .i_debug_clock_pin(pclk), .i_debug_data_pin(dpin), .o_debug_data_pin(),
    .o_debug_data_pin_oe_b(), .o_prg_denied(), .o_code_protected(), .o_debug_en(),
    .o_debug_stack_levels());
  pmcp_prog_model prg (.i_ref_clk(clk), .i_data_pin(dpin), .o_clk_pin(pclk),
    .o_data_pin(pdat));
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (den)
      seen <= 1'b1;
    if (cyc == 10000)
    begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic trd(input logic [21:0] a, input logic x, input logic [7:0] e, input logic b);
    req <= 1'b1;
    addr <= a;
    ext <= x;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk({7'h0, valid}, 8'h01);
    chk(data, e);
    chk({7'h0, blk}, {7'h0, b});
    chk({7'h0, blk_nb}, 8'h00);
    @(posedge clk);
  endtask
  task automatic pw(input logic [21:0] a, input logic [7:0] d);
    prg.xfer(1'b1, a, d, q);
  endtask
  task automatic prd(input logic [21:0] a, input logic [7:0] e);
    prg.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic t_reset();
    chk({6'h0, dbg, cp}, 8'h00);
    chk({6'h0, stk}, 8'h00);
    chk({7'h0, doe_b}, 8'h01);
  endtask
  task automatic t_load();
    pv <= 1'b1;
    @(posedge clk);
    pw(22'h000000, 8'ha5);
    pw(22'h000800, 8'h3c);
    pw(22'h003fff, 8'hc3);
    pw(22'h200000, 8'h5e);
    pw(22'h200007, 8'he5);
    prd(22'h200007, 8'he5);
    prd(22'h000000, 8'ha5);
  endtask
  task automatic t_table();
    trd(22'h000000, 1'b1, 8'ha5, 1'b0);
    trd(22'h003fff, 1'b1, 8'hc3, 1'b0);
    trd(22'h004000, 1'b1, 8'h00, 1'b0);
    trd(22'h1fffff, 1'b1, 8'h00, 1'b0);
    trd(22'h200007, 1'b1, 8'he5, 1'b0);
    trd(22'h300008, 1'b1, 8'h80, 1'b0);
  endtask
  task automatic t_external_table_read_protect_bit();
    logic [2:0] m;
    pmcp_pkg::pmcp_mode_t md;
    logic g, h;
    pw(22'h30000c, 8'h01);
    trd(22'h30000c, 1'b0, 8'h01, 1'b0);
    for (m = 3'h0; m < 3'h4; m++)
    begin
      md = pmcp_pkg::pmcp_mode_t'(m[1:0]);
      mode <= md;
      g = md == pmcp_pkg::PMCP_MODE_EXTENDED;
      h = g || md == pmcp_pkg::PMCP_MODE_BOOT_BLOCK;
      trd(22'h000000, 1'b1, h ? 8'h00 : 8'ha5, h);
      trd(22'h000800, 1'b1, g ? 8'h00 : 8'h3c, g);
      trd(22'h000000, 1'b0, 8'ha5, 1'b0);
    end
  endtask
  task automatic t_debug();
    pw(22'h300006, 8'h00);
    chk({6'h0, stk}, 8'h02);
    chk({7'h0, dbg}, 8'h01);
    pw(22'h300006, 8'h80);
    chk({7'h0, dbg}, 8'h00);
  endtask
  task automatic t_cp();
    chk({7'h0, seen}, 8'h00);
    pw(22'h300008, 8'h01);
    chk({7'h0, cp}, 8'h01);
    pw(22'h000000, 8'hff);
    chk({7'h0, seen}, 8'h01);
    prd(22'h000000, 8'h00);
    prd(22'h200000, 8'h5e);
    pw(22'h200001, 8'h77);
    prd(22'h200001, 8'h77);
    trd(22'h000000, 1'b0, 8'ha5, 1'b0);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_load();
    t_table();
    t_external_table_read_protect_bit();
    t_debug();
    t_cp();
    wrap_up();
  end
endmodule
bind pmcp_guard pmcp_guard_sva #(.PROG_BYTES(PROG_BYTES)) u_sva (.i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b), .i_mode(i_mode), .i_trd_req(i_trd_req), .i_trd_addr(i_trd_addr),
  .i_trd_from_ext(i_trd_from_ext), .o_trd_valid(o_trd_valid), .o_trd_data(o_trd_data),
  .o_trd_blocked(o_trd_blocked), .o_prg_denied(o_prg_denied),
  .o_code_protected(o_code_protected), .o_debug_en(o_debug_en),
  .o_debug_stack_levels(o_debug_stack_levels));
`default_nettype wire
